/* File: src/mts_pkg.sv */
// Package for the SC1 maintenance transmit scheduler.
// Assumes a single 250 MHz APB clock domain.
package mts_pkg;
   // Register byte offsets
   localparam logic [7:0] MTS_URGENT_OFS  = 8'h00;
   localparam logic [7:0] MTS_ROUTINE_OFS = 8'h04;
   localparam logic [7:0] MTS_CTRL_OFS    = 8'h08;
   localparam logic [7:0] MTS_STATUS_OFS  = 8'h0c;
   localparam logic [7:0] MTS_SC2_OFS     = 8'h10;
   // Field positions and widths
   localparam int MTS_CODE_W      = 4;
   localparam int MTS_CTRL_SIX    = 0;
   localparam int MTS_CTRL_MFEN   = 1;
   localparam int MTS_STAT_TICK   = 0;
   localparam int MTS_STAT_CNT    = 4;
   localparam int MTS_STAT_CODE   = 8;
   localparam int MTS_STAT_URG    = 12;
   // Reset values
   localparam logic [3:0] MTS_ROUTINE_RST = 4'hf;
   localparam logic [3:0] MTS_SC2_RST     = 4'hf;
   // Timing: one multiframe is 5 ms, a tick is six multiframes (30 ms)
   localparam int MTS_CLK_KHZ      = 250000;
   localparam int MTS_MF_MS        = 5;
   localparam int MTS_MF_CYC       = MTS_MF_MS * MTS_CLK_KHZ;
   localparam int MTS_TICK_MS      = 30;
   localparam int MTS_MF_PER_TICK  = MTS_TICK_MS / MTS_MF_MS;
   localparam int MTS_MFCNT_W      = 21;
   localparam int MTS_TICKCNT_W    = 3;
endpackage : mts_pkg

/* File: src/mts_sched.sv */
// SC1 maintenance transmit scheduler: urgent queue, routine register,
// multiframe timer and the six-multiframe tick status.
// Assumes an APB master on pclk; the line framer reads the sent code.
`timescale 1ns/10ps
`default_nettype none
module mts_sched #(
   // Multiframe length in pclk cycles; only a bench shortens it
   parameter int MF_CYC = mts_pkg::MTS_MF_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Line side
   output logic [mts_pkg::MTS_CODE_W-1:0] sc1_tx_code,
   output logic [mts_pkg::MTS_CODE_W-1:0] sc2_maint_tx_reg,
   output logic                           mf_boundary,
   output logic                           multiframe_tick_interrupt
);
   import mts_pkg::*;

   typedef logic [MTS_CODE_W-1:0] mts_code_t;

   typedef struct packed {
      mts_code_t                 q0;       // Oldest urgent entry
      mts_code_t                 q1;
      logic [1:0]                qcnt;
      mts_code_t                 routine;
      mts_code_t                 sc2;
      mts_code_t                 code;     // Code on the line now
      logic                      urg_now;  // Current multiframe is urgent
      logic                      six_en;
      logic                      mf_en;
      logic                      tick;     // Sticky tick status
      logic [MTS_MFCNT_W-1:0]    mfcnt;
      logic [MTS_TICKCNT_W-1:0]  tickcnt;
      logic                      bound;
      logic [31:0]               rdata;
   } mts_state_t;

   mts_state_t s_q;
   mts_state_t s_d;

   localparam logic [MTS_MFCNT_W-1:0] MF_LAST =
      MTS_MFCNT_W'(MF_CYC - 1);
   localparam logic [MTS_TICKCNT_W-1:0] TICK_LAST =
      MTS_TICKCNT_W'(MTS_MF_PER_TICK - 1);

   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   logic last_mf;

   // Decode helper used for every register compare
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // APB always answers in the first access cycle
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign mapped  = hit(paddr, MTS_URGENT_OFS) | hit(paddr, MTS_ROUTINE_OFS)
                  | hit(paddr, MTS_CTRL_OFS) | hit(paddr, MTS_STATUS_OFS)
                  | hit(paddr, MTS_SC2_OFS);
   assign last_mf = s_q.bound && (s_q.tickcnt == TICK_LAST);

   // Next state
   always_comb begin
      s_d       = s_q;
      s_d.bound = 1'b0;
      // Multiframe timer runs while enabled
      if (s_q.mf_en) begin
         if (s_q.mfcnt == MF_LAST) begin
            s_d.mfcnt = '0;
            s_d.bound = 1'b1;
         end else begin
            s_d.mfcnt = s_q.mfcnt + 1'b1;
         end
      end
      // Boundary: pick urgent entry first, else routine code
      if (s_q.bound) begin
         if (s_q.qcnt != 2'd0) begin
            s_d.code    = s_q.q0;
            s_d.urg_now = 1'b1;
            s_d.q0      = s_q.q1;
            s_d.qcnt    = s_q.qcnt - 2'd1;
         end else begin
            s_d.code    = s_q.routine;
            s_d.urg_now = 1'b0;
         end
         s_d.tickcnt = last_mf ? '0 : s_q.tickcnt + 1'b1;
      end
      // Tick every six multiframes; set wins over a same-cycle clear.
      // Only a tick the read reported is cleared: one set during the
      // setup cycle of that read would otherwise be lost.
      if (rd && hit(paddr, MTS_STATUS_OFS) && s_q.rdata[MTS_STAT_TICK]) begin
         s_d.tick = 1'b0;
      end
      if (last_mf && s_q.six_en) begin
         s_d.tick = 1'b1;
      end
      // Register writes
      if (wr) begin
         if (hit(paddr, MTS_URGENT_OFS)) begin
            // Queue write sees the pop above through s_d
            case (s_d.qcnt)
               2'd0: begin
                  s_d.q0   = pwdata[MTS_CODE_W-1:0];
                  s_d.qcnt = 2'd1;
               end
               2'd1: begin
                  s_d.q1   = pwdata[MTS_CODE_W-1:0];
                  s_d.qcnt = 2'd2;
               end
               default: begin
                  s_d.q0   = s_d.q1;
                  s_d.q1   = pwdata[MTS_CODE_W-1:0];
                  s_d.qcnt = 2'd2;
               end
            endcase
         end
         if (hit(paddr, MTS_ROUTINE_OFS)) begin
            s_d.routine = pwdata[MTS_CODE_W-1:0];
         end
         if (hit(paddr, MTS_SC2_OFS)) begin
            s_d.sc2 = pwdata[MTS_CODE_W-1:0];
         end
         if (hit(paddr, MTS_CTRL_OFS)) begin
            s_d.six_en = pwdata[MTS_CTRL_SIX];
            s_d.mf_en  = pwdata[MTS_CTRL_MFEN];
            // Restart the tick phase; the first tick is 30 ms, or 25 ms if the write meets the timer wrap (mfcnt == MF_LAST)
            if (pwdata[MTS_CTRL_SIX] && !s_q.six_en) begin
               s_d.tickcnt = '0;
               s_d.mfcnt   = '0;
            end
         end
      end
      // Read data captured during setup so prdata is a flop at access
      s_d.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         if (hit(paddr, MTS_URGENT_OFS)) begin
            s_d.rdata = {26'h0, s_q.qcnt, s_q.q0};
         end else if (hit(paddr, MTS_ROUTINE_OFS)) begin
            s_d.rdata = {28'h0, s_q.routine};
         end else if (hit(paddr, MTS_CTRL_OFS)) begin
            s_d.rdata[MTS_CTRL_SIX]  = s_q.six_en;
            s_d.rdata[MTS_CTRL_MFEN] = s_q.mf_en;
         end else if (hit(paddr, MTS_STATUS_OFS)) begin
            s_d.rdata[MTS_STAT_TICK] = s_q.tick;
            s_d.rdata[MTS_STAT_CNT +: MTS_TICKCNT_W] = s_q.tickcnt;
            s_d.rdata[MTS_STAT_CODE +: MTS_CODE_W] = s_q.code;
            s_d.rdata[MTS_STAT_URG] = s_q.urg_now;
         end else if (hit(paddr, MTS_SC2_OFS)) begin
            s_d.rdata = {28'h0, s_q.sc2};
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q         <= '0;
         s_q.routine <= MTS_ROUTINE_RST;
         s_q.sc2     <= MTS_SC2_RST;
         s_q.code    <= MTS_ROUTINE_RST;
         s_q.mf_en   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign prdata                    = s_q.rdata;
   assign pready                    = 1'b1;
   assign pslverr                   = acc & ~mapped;
   assign sc1_tx_code               = s_q.code;
   assign sc2_maint_tx_reg          = s_q.sc2;
   assign mf_boundary               = s_q.bound;
   assign multiframe_tick_interrupt = s_q.tick;

   // Assertions
   property p_urgent_first;
      @(posedge pclk) disable iff (!presetn)
      (s_q.bound && s_q.qcnt != 2'd0) |=> (s_q.code == $past(s_q.q0))
                                          && s_q.urg_now;
   endproperty
   a_urgent_first: assert property (p_urgent_first)
      else $error("urgent entry not sent at boundary");

   property p_routine_when_empty;
      @(posedge pclk) disable iff (!presetn)
      (s_q.bound && s_q.qcnt == 2'd0) |=>
         (s_q.code == $past(s_q.routine)) && !s_q.urg_now;
   endproperty
   a_routine_when_empty: assert property (p_routine_when_empty)
      else $error("routine code not sent with empty queue");

   property p_one_mf_only;
      @(posedge pclk) disable iff (!presetn)
      (s_q.bound && s_q.qcnt == 2'd1 && !wr) |=> (s_q.qcnt == 2'd0);
   endproperty
   a_one_mf_only: assert property (p_one_mf_only)
      else $error("urgent entry not popped after sending");

   property p_overflow;
      @(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, MTS_URGENT_OFS) && s_q.qcnt == 2'd2 && !s_q.bound)
         |=> (s_q.q0 == $past(s_q.q1)) && (s_q.q1 == $past(pwdata[3:0]))
             && (s_q.qcnt == 2'd2);
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("full queue write did not drop oldest");

   property p_code_width;
      @(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, MTS_ROUTINE_OFS)) |=>
         (s_q.routine == $past(pwdata[3:0]));
   endproperty
   a_code_width: assert property (p_code_width)
      else $error("routine register did not take 4-bit code");

   property p_tick;
      @(posedge pclk) disable iff (!presetn)
      (last_mf && s_q.six_en) |=> s_q.tick;
   endproperty
   a_tick: assert property (p_tick)
      else $error("tick status not raised after six multiframes");

   property p_tick_only_six;
      @(posedge pclk) disable iff (!presetn)
      $rose(s_q.tick) |-> $past(last_mf) && $past(s_q.six_en);
   endproperty
   a_tick_only_six: assert property (p_tick_only_six)
      else $error("tick status rose off the six-frame boundary");

   property p_code_stable;
      @(posedge pclk) disable iff (!presetn)
      !s_q.bound |=> $stable(s_q.code);
   endproperty
   a_code_stable: assert property (p_code_stable)
      else $error("line code changed inside a multiframe");

   // A reported tick clears on the access of its status read
   sequence s_tick_reported;
      rd && hit(paddr, MTS_STATUS_OFS) && s_q.rdata[MTS_STAT_TICK];
   endsequence

   property p_tick_clear;
      @(posedge pclk) disable iff (!presetn)
      (s_tick_reported ##0 !(last_mf && s_q.six_en)) |=> !s_q.tick;
   endproperty
   a_tick_clear: assert property (p_tick_clear)
      else $error("reported tick status not cleared by its read");

   property p_tick_kept;
      @(posedge pclk) disable iff (!presetn)
      (s_q.tick && !(rd && hit(paddr, MTS_STATUS_OFS))) |=> s_q.tick;
   endproperty
   a_tick_kept: assert property (p_tick_kept)
      else $error("tick status dropped without a status read");

   // Boundaries fall on the timer wrap: the timer restarts at each
   property p_bound_wrap;
      @(posedge pclk) disable iff (!presetn)
      s_q.bound |-> (s_q.mfcnt == '0);
   endproperty
   a_bound_wrap: assert property (p_bound_wrap)
      else $error("boundary pulse off the multiframe wrap");

   property p_routine_kept;
      @(posedge pclk) disable iff (!presetn)
      !(wr && hit(paddr, MTS_ROUTINE_OFS)) |=> $stable(s_q.routine);
   endproperty
   a_routine_kept: assert property (p_routine_kept)
      else $error("routine code changed without a write");

   property p_first_push;
      @(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, MTS_URGENT_OFS) && s_q.qcnt == 2'd0)
         |=> (s_q.qcnt == 2'd1) && (s_q.q0 == $past(pwdata[3:0]));
   endproperty
   a_first_push: assert property (p_first_push)
      else $error("write to empty urgent queue not held");
endmodule : mts_sched
`default_nettype wire

/* File: verification/mts_line_rx.sv */
// Line-side listener: logs the SC1 code put on the wire per multiframe.
// Assumes one pclk domain shared with the scheduler.
`timescale 1ns/10ps
`default_nettype none
module mts_line_rx (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Line side
   input  wire logic [3:0] sc1_tx_code,
   input  wire logic       mf_boundary,
   output var  int         n_mf,
   output logic      [3:0] last_code
);
   logic seen_q;
   // Code settles one cycle after the boundary pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q    <= 1'b0;
         n_mf      <= 0;
         last_code <= 4'hf;
      end else begin
         seen_q <= mf_boundary;
         if (seen_q) begin
            n_mf      <= n_mf + 1;
            last_code <= sc1_tx_code;
         end
      end
   end
endmodule : mts_line_rx
`default_nettype wire

/* File: verification/mts_sched_test.sv */
// Self-checking bench for the SC1 maintenance transmit scheduler.
// Assumes an APB slave that answers in time; multiframes are shortened
// to TB_MF_CYC cycles so boundaries and ticks fit in the run.
`timescale 1ns/10ps
`default_nettype none
module mts_sched_test;
   import mts_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        mf_boundary, tick, err;
   logic [3:0]  sc1_tx_code, sc2_code, line_code;
   logic [3:0]  q [2];
   int          n_mf, qn, mismatches, n_tests;
   logic [3:0]  routine_m, exp_c;
   logic [31:0] exp_st;
   logic        extend_routine_flag;

   // Short multiframe keeps the walk well inside the cycle budget
   localparam int TB_MF_CYC = 100;
   // Bench code values for the messages; the values are arbitrary
   localparam logic [3:0] LOSS_OF_POWER_MSG          = 4'h1;
   localparam logic [3:0] FAR_END_CODE_VIOLATION_MSG = 4'h2;
   localparam logic [3:0] DOWNSTREAM_TEST_ERROR_MSG  = 4'h3;
   localparam logic [3:0] LOSS_OF_SIGNAL_MSG         = 4'h4;
   localparam logic [3:0] OTHER_INDICATION_MSG       = 4'h5;

   mts_sched #(.MF_CYC(TB_MF_CYC)) u_mts_sched (.pclk(pclk),
      .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sc1_tx_code(sc1_tx_code), .sc2_maint_tx_reg(sc2_code),
      .mf_boundary(mf_boundary), .multiframe_tick_interrupt(tick));
   mts_line_rx u_mts_line_rx (.pclk(pclk), .presetn(presetn),
      .sc1_tx_code(sc1_tx_code), .mf_boundary(mf_boundary),
      .n_mf(n_mf), .last_code(line_code));

   // 250 MHz clock
   always #2 pclk = ~pclk;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   // Repeatable xorshift stream
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Expected urgent read: pending count in [5:4], oldest code below
   function automatic logic [31:0] urg_exp();
      return {26'h0, 2'(qn), q[0]};
   endfunction : urg_exp

   // Expected status word: urgent flag, line code, tick index, tick bit
   function automatic logic [31:0] st_exp(input logic [3:0] c, input logic u,
                                          input logic [2:0] n, input logic t);
      logic [31:0] s;
      s = 32'h0;
      s[MTS_STAT_TICK] = t;
      s[MTS_STAT_CNT +: 3] = n;
      s[MTS_STAT_CODE +: 4] = c;
      s[MTS_STAT_URG] = u;
      return s;
   endfunction : st_exp

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         mismatches++;
         wrap_up();
      end
   endtask : apb

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(what, exp & m, rd & m);
   endtask : rd_chk

   // Model keeps oldest-first order; a third write drops the oldest
   task automatic push(input logic [31:0] d);
      apb(1'b1, MTS_URGENT_OFS, d);
      if (qn < 2) begin
         q[qn] = d[3:0];
         qn++;
      end else begin
         q[0] = q[1];
         q[1] = d[3:0];
      end
   endtask : push

   // Routine register write, mirrored in the bench's model
   task automatic set_routine(input logic [3:0] c);
      apb(1'b1, MTS_ROUTINE_OFS, {28'h0, c});
      routine_m = c;
   endtask : set_routine

   // Bounded wait until the listener has logged multiframe n
   task automatic wait_mf(input int n);
      int i;
      for (i = 0; i < 2 * TB_MF_CYC; i++) begin
         @(posedge pclk);
         if (n_mf == n) break;
      end
      if (i == 2 * TB_MF_CYC) begin
         mismatches++;
         wrap_up();
      end
   endtask : wait_mf

   task automatic after_reset;
      qn = 0;
      rd_chk("routine", MTS_ROUTINE_OFS, 32'hf, '1);
      rd_chk("sc2", MTS_SC2_OFS, 32'hf, '1);
      rd_chk("ctrl", MTS_CTRL_OFS, 32'h2, '1);
      rd_chk("status", MTS_STATUS_OFS, 32'hf00, '1);
      rd_chk("urgent count", MTS_URGENT_OFS, 32'h0, 32'h30);
      chk("line code", 32'hf, {28'h0, sc1_tx_code});
   endtask : after_reset

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seed = 32'd66;
      mismatches = 0;
      n_tests = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      after_reset();
      // Hold the multiframe timer so the queue tests see no boundary
      apb(1'b1, MTS_CTRL_OFS, 32'h0);
      $display("test reset done");
      // Full-width random writes keep only the 4-bit code
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         apb(1'b1, MTS_ROUTINE_OFS, seed);
         apb(1'b1, MTS_SC2_OFS, ~seed);
         rd_chk("routine", MTS_ROUTINE_OFS, {28'h0, seed[3:0]}, '1);
         chk("sc2 port", {28'h0, ~seed[3:0]}, {28'h0, sc2_code});
      end
      $display("test code registers done");
      // Back-to-back urgent writes, then random overflow traffic
      push(32'h1);
      push(32'h2);
      rd_chk("urgent two", MTS_URGENT_OFS, urg_exp(), '1);
      push(32'h3);
      rd_chk("urgent third", MTS_URGENT_OFS, urg_exp(), '1);
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         push(seed);
         rd_chk("urgent rand", MTS_URGENT_OFS, urg_exp(), '1);
      end
      $display("test urgent queue done");
      // Unmapped place refused without side effect
      apb(1'b1, 8'h14, 32'h5);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped rd", 32'h0, rd);
      chk("unmapped rd err", 32'h1, {31'h0, err});
      rd_chk("urgent kept", MTS_URGENT_OFS, urg_exp(), '1);
      $display("test unmapped done");
      // Init: routine code, then tick-every-six; nothing before a boundary
      set_routine(LOSS_OF_SIGNAL_MSG);
      apb(1'b1, MTS_CTRL_OFS, 32'h3);
      rd_chk("ctrl", MTS_CTRL_OFS, 32'h3, '1);
      rd_chk("status", MTS_STATUS_OFS, 32'hf00, '1);
      chk("tick", 32'h0, {31'h0, tick});
      chk("boundaries", 32'h0, n_mf);
      chk("line code", 32'hf, {28'h0, line_code});
      $display("test tick enable done");
      // Multiframe walk: the bench plays the controller at each boundary
      extend_routine_flag = 1'b0;
      for (int mf = 1; mf <= 16; mf++) begin
         wait_mf(mf);
         if (qn > 0) begin
            exp_c = q[0];
            q[0] = q[1];
            qn--;
         end else begin
            exp_c = routine_m;
         end
         chk("line code", {28'h0, exp_c}, {28'h0, line_code});
         chk("tick", {31'h0, mf % 6 == 0}, {31'h0, tick});
         if (mf == 1) begin
            exp_st = st_exp(exp_c, 1'b1, 3'd1, 1'b0);
            rd_chk("status urgent", MTS_STATUS_OFS, exp_st, '1);
         end
         if (mf % 6 == 0) begin
            exp_st = st_exp(exp_c, 1'b0, 3'd0, 1'b1);
            rd_chk("tick status", MTS_STATUS_OFS, exp_st, '1);
            rd_chk("tick cleared", MTS_STATUS_OFS, 32'h0, 32'h1);
            if (extend_routine_flag) begin
               extend_routine_flag = 1'b0;
            end else begin
               set_routine(OTHER_INDICATION_MSG);
            end
         end
         if (mf == 2) begin
            push({28'h0, DOWNSTREAM_TEST_ERROR_MSG});
            extend_routine_flag = 1'b1;
            set_routine(routine_m);
         end
         if (mf == 3) begin
            push({28'h0, FAR_END_CODE_VIOLATION_MSG});
            set_routine(routine_m);
         end
         if (mf == 13) begin
            push({28'h0, DOWNSTREAM_TEST_ERROR_MSG});
            push({28'h0, FAR_END_CODE_VIOLATION_MSG});
            push({28'h0, LOSS_OF_POWER_MSG});
            set_routine(LOSS_OF_POWER_MSG);
            extend_routine_flag = 1'b1;
         end
      end
      $display("test multiframe walk done");
      // Second reset in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      after_reset();
      $display("test mid reset done");
      wrap_up();
   end
endmodule : mts_sched_test
`default_nettype wire
